// *** drive_model.sv ***
// Motor drive inputs: pull-up pads and high-time counters
`timescale 1ns/100ps
module drive_model #(
  parameter int NP = 6  // pads watched
) (
  input  wire logic          sys_clk,   // system clock
  input  wire logic [NP-1:0] pin_out,   // pad values
  input  wire logic [NP-1:0] pin_oe_n,  // low while driven
  input  wire logic [NP-1:0] ext_low,   // pull released pads low
  input  wire logic          clr,       // clear counters
  output logic      [NP-1:0] pin_in,    // resolved pad levels
  output logic      [15:0]   hi [NP]    // high cycles per pad
);
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else pin_in[i] = !ext_low[i];
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < NP; i++) begin
      if (clr) hi[i] <= 16'h0;
      else hi[i] <= hi[i] + {15'h0, pin_in[i]};
    end
  end
endmodule

// *** pin_stage.sv ***
// One connector pin stage: polarity, sink-only drive and readback
`timescale 1ns/100ps
`include "pwm_gen_cfg.svh"
module pin_stage (
  input  logic                     sys_clk,   // system clock
  input  logic                     nrst,      // async reset, active low
  input  logic                     src,       // generator source value
  input  pwm_gen_pkg::pin_cfg_type cfg,       // flip and sink-only select
  input  logic                     pad_i,     // pin level from the pad
  output logic                     pad_o,     // value driven on the pad
  output logic                     pad_oe_n,  // low while driving
  output logic                     level,     // sampled pin level
  output logic                     level_inv  // complement of level
);
  logic val;
  logic s1_q;
  logic s2_q;

  assign val = src ^ cfg.flip;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pad_o    <= 1'b0;
      pad_oe_n <= 1'b1;
    end else if (cfg.sink) begin
      pad_o    <= 1'b0;
      pad_oe_n <= val;
    end else begin
      pad_o    <= val;
      pad_oe_n <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= pad_i;
      s2_q <= s1_q;
    end
  end

  assign level     = s2_q;
  assign level_inv = ~s2_q;
endmodule

// *** pulse_core.sv ***
// One generator: duty command to pulse width or density outputs
`timescale 1ns/100ps
`include "pwm_gen_cfg.svh"
module pulse_core #(
  parameter int RAMP_W = `RAMP_W  // PWM ramp resolution
) (
  input  logic                     sys_clk,    // system clock
  input  logic                     nrst,       // async reset, active low
  input  pwm_gen_pkg::gen_cfg_type cfg,        // enable, format, duty
  input  logic [RAMP_W-1:0]        ramp,       // shared PWM ramp
  input  logic                     slot_tick,  // shared PDM slot enable
  output pwm_gen_pkg::gen_out_type out_q       // registered outputs
);
  logic [16:0]       ext;
  logic [16:0]       abs_v;
  logic [`MAG_W-1:0] mag;
  logic              neg;
  logic              pwm_on;
  logic [`MAG_W:0]   pdm_sum;
  logic [`MAG_W-1:0] pdm_acc_q;
  logic              pdm_bit_q;

  assign neg    = cfg.duty[15];
  assign ext    = {cfg.duty[15], cfg.duty};
  assign abs_v  = neg ? 17'h0 - ext : ext;
  assign mag    = (abs_v > {2'h0, `DUTY_FULL}) ? `DUTY_FULL : abs_v[`MAG_W-1:0];
  assign pwm_on = {1'b0, ramp} < mag[`MAG_W-1 -: RAMP_W+1];
  assign pdm_sum = {1'b0, pdm_acc_q} + {1'b0, mag};

  // Carry of the density accumulator gives one pulse slot
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pdm_acc_q <= '0;
      pdm_bit_q <= 1'b0;
    end else if (!cfg.enable) begin
      pdm_acc_q <= '0;
      pdm_bit_q <= 1'b0;
    end else if (slot_tick) begin
      if (pdm_sum >= {1'b0, `DUTY_FULL}) begin
        pdm_acc_q <= pdm_sum[`MAG_W-1:0] - `DUTY_FULL;
        pdm_bit_q <= 1'b1;
      end else begin
        pdm_acc_q <= pdm_sum[`MAG_W-1:0];
        pdm_bit_q <= 1'b0;
      end
    end
  end

  // Format is read live so it may change at any time
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_q <= '{inhibit: 1'b1, primary: 1'b0, secondary: 1'b0};
    end else if (!cfg.enable) begin
      out_q <= '{inhibit: 1'b1, primary: 1'b0, secondary: 1'b0};
    end else begin
      out_q.inhibit <= 1'b0;
      case (cfg.format)
        `FMT_PWM_DIR: begin
          out_q.primary   <= pwm_on;
          out_q.secondary <= neg;
        end
        `FMT_UP_DOWN: begin
          out_q.primary   <= pwm_on & ~neg;
          out_q.secondary <= pwm_on & neg;
        end
        `FMT_PDM_DIR: begin
          out_q.primary   <= pdm_bit_q;
          out_q.secondary <= neg;
        end
        `FMT_DIR_PWM: begin
          out_q.primary   <= neg;
          out_q.secondary <= pwm_on;
        end
        default: begin
          out_q.primary   <= 1'b0;
          out_q.secondary <= 1'b0;
        end
      endcase
    end
  end
endmodule

// *** pwm_gen_cfg.svh ***
// Constants for the pulse generator block
// Contract
// - Enabled instance drops drive inhibit and pulses; disabled holds inhibit, outputs quiet.
// - Each instance owns three pins: drive inhibit, primary_out, secondary_out.
// - Format 1: pulse width on primary_out, direction on secondary_out.
// - Format 2: up pulses on primary_out, down pulses on secondary_out.
// - Format 3: pulse density on primary_out, direction on secondary_out.
// - Format 4: direction on primary_out, pulse width on secondary_out.
// - Duty command saturates to the span minus one to plus one.
// - Density mode decides pulse or space each slot tick, one slot long.
// - Half-scale density command gives strictly alternating pulse and space.
// - Density slot rate programmable from clock/65536 to just under clock.
// - One density slot rate shared by all instances.
// - One pulse period rate shared by all instances in formats 1, 2 and 4.
// - Rates follow fast_clock; too-high requests clamp to the maximum.
// - Format may change while running; set once at start is advised.
// - Inversion happens in the pin stage via polarity_flip.
// - Sink-only clear: pin actively driven to the (flipped) source value.
// - Sink-only set: (flipped) source 0 pulls low, (flipped) source 1 releases the pin.
// - Released sink-only pin may be driven externally; readback shows real level.
// - Each pin stage reads back the level and its complement.
`ifndef PWM_GEN_CFG_SVH
`define PWM_GEN_CFG_SVH

`define DUTY_W        16
`define MAG_W         15
`define DUTY_FULL     15'h4000
`define RAMP_W        9
`define PWM_ACC_W     24
`define PDM_ACC_W     16
`define PWM_RATE_MAX  24'hFFFFFF
`define PDM_RATE_MAX  16'hFFFF
`define PWM_RATE_RST  24'h000100
`define PDM_RATE_RST  16'h0100

`define FMT_PWM_DIR   3'h1
`define FMT_UP_DOWN   3'h2
`define FMT_PDM_DIR   3'h3
`define FMT_DIR_PWM   3'h4

`define ADDR_W        8
`define ADDR_PWM_RATE 8'h00
`define ADDR_PDM_RATE 8'h04
`define ADDR_RAMP     8'h08
`define GEN_STRIDE    8'h10
`define OFS_DUTY      4'h0
`define OFS_MODE      4'h4
`define OFS_PINCFG    4'h8
`define OFS_PINSTAT   4'hC

`define MODE_EN_BIT   0
`define MODE_FMT_LSB  4
`define PINCFG_FLIP   0
`define PINCFG_SINK   4

`endif

// *** pwm_gen_pkg.sv ***
// Shared types of the pulse generator block
package pwm_gen_pkg;

  typedef struct packed {
    logic               enable;
    logic [2:0]         format;
    logic signed [15:0] duty;
  } gen_cfg_type;

  typedef struct packed {
    logic flip;
    logic sink;
  } pin_cfg_type;

  typedef struct packed {
    logic inhibit;
    logic primary;
    logic secondary;
  } gen_out_type;

endpackage

// *** pwm_pdm_generator_with_pin_stage.sv ***
// Top: register port, shared rate generators, generators and pin stages
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`include "pwm_gen_cfg.svh"
module pwm_pdm_generator_with_pin_stage #(
  parameter int N_GEN  = 4,        // generator instances
  parameter int RAMP_W = `RAMP_W   // PWM ramp resolution
) (
  input  logic                  sys_clk,    // 125 MHz system clock
  input  logic                  nrst,       // async reset, active low
  input  logic [`ADDR_W-1:0]    reg_addr,   // register byte address
  input  logic [31:0]           reg_wdata,  // register write data
  input  logic                  reg_wr,     // write strobe
  input  logic                  reg_rd,     // read strobe
  output logic [31:0]           reg_rdata,  // read data, cycle after strobe
  input  logic [3*N_GEN-1:0]    pin_in,     // pad levels, async
  output logic [3*N_GEN-1:0]    pin_out,    // pad output values
  output logic [3*N_GEN-1:0]    pin_oe_n    // pad drive enables, low drives
);
  localparam int PIN_N = 3 * N_GEN;

  // Register state
  logic [`PWM_ACC_W-1:0]    pwm_rate_q;
  logic [`PDM_ACC_W-1:0]    pdm_rate_q;
  pwm_gen_pkg::gen_cfg_type gen_cfg_q [N_GEN];
  pwm_gen_pkg::pin_cfg_type pin_cfg_q [PIN_N];
  logic [31:0]              rdata_q;

  // Shared timing
  logic [`PWM_ACC_W-1:0]    pwm_acc_q;
  logic [`PWM_ACC_W:0]      pwm_sum;
  logic                     ramp_tick;
  logic [RAMP_W-1:0]        ramp_q;
  logic [`PDM_ACC_W-1:0]    pdm_acc_q;
  logic [`PDM_ACC_W:0]      pdm_sum;
  logic                     slot_tick;

  // Per pin and per generator signals
  logic [PIN_N-1:0]         pin_src;
  logic [PIN_N-1:0]         pin_level;
  logic [PIN_N-1:0]         pin_level_inv;
  pwm_gen_pkg::gen_out_type gen_out [N_GEN];

  // Address decode helpers
  logic                     gen_hit;
  logic [3:0]               gen_idx;
  logic [3:0]               gen_ofs;

  // Generator index of an address; zero page holds shared registers
  function automatic logic [3:0] addr_gen(input logic [`ADDR_W-1:0] a);
    addr_gen = a[7:4] - 4'h1;
  endfunction

  // True if the address falls in an existing generator page
  function automatic logic addr_in_gen(input logic [`ADDR_W-1:0] a);
    addr_in_gen = (a[7:4] != 4'h0) && ({28'h0, a[7:4]} <= N_GEN);
  endfunction

  assign gen_hit = addr_in_gen(reg_addr);
  assign gen_idx = addr_gen(reg_addr);
  assign gen_ofs = reg_addr[3:0];

  // Shared pulse period rate, clamped on write
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pwm_rate_q <= `PWM_RATE_RST;
    end else if (reg_wr && reg_addr == `ADDR_PWM_RATE) begin
      if (reg_wdata > {8'h0, `PWM_RATE_MAX}) begin
        pwm_rate_q <= `PWM_RATE_MAX;
      end else begin
        pwm_rate_q <= reg_wdata[`PWM_ACC_W-1:0];
      end
    end
  end

  // Shared density slot rate, clamped on write
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pdm_rate_q <= `PDM_RATE_RST;
    end else if (reg_wr && reg_addr == `ADDR_PDM_RATE) begin
      if (reg_wdata > {16'h0, `PDM_RATE_MAX}) begin
        pdm_rate_q <= `PDM_RATE_MAX;
      end else begin
        pdm_rate_q <= reg_wdata[`PDM_ACC_W-1:0];
      end
    end
  end

  // Per generator and per pin configuration registers
  genvar g;
  generate
    for (g = 0; g < N_GEN; g++) begin : g_cfg
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          gen_cfg_q[g] <= '{enable: 1'b0, format: `FMT_PWM_DIR, duty: 16'sh0000};
        end else if (reg_wr && gen_hit && gen_idx == 4'(g)) begin
          if (gen_ofs == `OFS_DUTY) begin
            gen_cfg_q[g].duty <= reg_wdata[`DUTY_W-1:0];
          end
          if (gen_ofs == `OFS_MODE) begin
            gen_cfg_q[g].enable <= reg_wdata[`MODE_EN_BIT];
            gen_cfg_q[g].format <= reg_wdata[`MODE_FMT_LSB +: 3];
          end
        end
      end

      for (genvar p = 0; p < 3; p++) begin : g_pcfg
        always_ff @(posedge sys_clk or negedge nrst) begin
          if (!nrst) begin
            pin_cfg_q[3*g+p] <= '{flip: 1'b0, sink: 1'b0};
          end else if (reg_wr && gen_hit && gen_idx == 4'(g)
                       && gen_ofs == `OFS_PINCFG) begin
            pin_cfg_q[3*g+p].flip <= reg_wdata[`PINCFG_FLIP + p];
            pin_cfg_q[3*g+p].sink <= reg_wdata[`PINCFG_SINK + p];
          end
        end
      end
    end
  endgenerate

  // Period ramp advances on a phase accumulator carry
  assign pwm_sum   = {1'b0, pwm_acc_q} + {1'b0, pwm_rate_q};
  assign ramp_tick = pwm_sum[`PWM_ACC_W];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pwm_acc_q <= '0;
    end else begin
      pwm_acc_q <= pwm_sum[`PWM_ACC_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ramp_q <= '0;
    end else if (ramp_tick) begin
      ramp_q <= ramp_q + 1'b1;
    end
  end

  // Slot enable from a second accumulator; all ones fires almost every cycle
  assign pdm_sum   = {1'b0, pdm_acc_q} + {1'b0, pdm_rate_q};
  assign slot_tick = pdm_sum[`PDM_ACC_W];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pdm_acc_q <= '0;
    end else begin
      pdm_acc_q <= pdm_sum[`PDM_ACC_W-1:0];
    end
  end

  // Generators and their three pins each
  generate
    for (g = 0; g < N_GEN; g++) begin : g_gen
      pulse_core #(
        .RAMP_W (RAMP_W)
      ) u_core (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .cfg       (gen_cfg_q[g]),
        .ramp      (ramp_q),
        .slot_tick (slot_tick),
        .out_q     (gen_out[g])
      );

      assign pin_src[3*g]   = gen_out[g].inhibit;
      assign pin_src[3*g+1] = gen_out[g].primary;
      assign pin_src[3*g+2] = gen_out[g].secondary;
    end

    for (g = 0; g < PIN_N; g++) begin : g_pin
      pin_stage u_pin (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .src       (pin_src[g]),
        .cfg       (pin_cfg_q[g]),
        .pad_i     (pin_in[g]),
        .pad_o     (pin_out[g]),
        .pad_oe_n  (pin_oe_n[g]),
        .level     (pin_level[g]),
        .level_inv (pin_level_inv[g])
      );
    end
  endgenerate

  // Read mux; data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else if (!reg_rd) begin
      rdata_q <= '0;
    end else if (reg_addr == `ADDR_PWM_RATE) begin
      rdata_q <= {8'h0, pwm_rate_q};
    end else if (reg_addr == `ADDR_PDM_RATE) begin
      rdata_q <= {16'h0, pdm_rate_q};
    end else if (reg_addr == `ADDR_RAMP) begin
      rdata_q <= 32'(ramp_q);
    end else if (gen_hit) begin
      rdata_q <= '0;
      for (int i = 0; i < N_GEN; i++) begin
        if (gen_idx == 4'(i)) begin
          case (gen_ofs)
            `OFS_DUTY: begin
              rdata_q <= {16'h0, gen_cfg_q[i].duty};
            end
            `OFS_MODE: begin
              rdata_q <= 32'({gen_cfg_q[i].format, 3'h0, gen_cfg_q[i].enable});
            end
            `OFS_PINCFG: begin
              rdata_q <= 32'({pin_cfg_q[3*i+2].sink, pin_cfg_q[3*i+1].sink,
                              pin_cfg_q[3*i].sink, 1'b0,
                              pin_cfg_q[3*i+2].flip, pin_cfg_q[3*i+1].flip,
                              pin_cfg_q[3*i].flip});
            end
            `OFS_PINSTAT: begin
              rdata_q <= 32'({pin_level_inv[3*i +: 3], 1'b0,
                              pin_level[3*i +: 3]});
            end
            default: begin
              rdata_q <= '0;
            end
          endcase
        end
      end
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;
endmodule

// *** pwm_pdm_monitor.sv ***
// Port checker for the pulse generator top, with its bind
`timescale 1ns/100ps
`include "pwm_gen_cfg.svh"
module pwm_pdm_monitor #(
  parameter int N_GEN = 4  // generator instances
) (
  input wire logic               sys_clk,    // system clock
  input wire logic               nrst,       // async reset, active low
  input wire logic [`ADDR_W-1:0] reg_addr,   // register address
  input wire logic [31:0]        reg_wdata,  // write data
  input wire logic               reg_wr,     // write strobe
  input wire logic               reg_rd,     // read strobe
  input wire logic [31:0]        reg_rdata,  // read data
  input wire logic [3*N_GEN-1:0] pin_in,     // pad levels
  input wire logic [3*N_GEN-1:0] pin_out,    // pad values
  input wire logic [3*N_GEN-1:0] pin_oe_n    // pad drive enables
);
  logic [2:0] fl_q;
  logic [2:0] sk_q;
  logic [2:0] fmt_q;
  logic       en_q;
  logic       neg_q;
  logic [1:0] q_cnt_q;
  logic       settled;
  logic       plain;

  assign settled = (q_cnt_q == 2'h3);
  assign plain   = settled && fl_q == 3'h0 && sk_q == 3'h0;

  // Cycles since the last write to generator 0
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) q_cnt_q <= 2'h0;
    else if (reg_wr && reg_addr[7:4] == 4'h1) q_cnt_q <= 2'h0;
    else if (!settled) q_cnt_q <= q_cnt_q + 2'h1;
  end

  // Shadow of generator 0 settings
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      en_q  <= 1'b0;
      fmt_q <= `FMT_PWM_DIR;
      neg_q <= 1'b0;
      fl_q  <= 3'h0;
      sk_q  <= 3'h0;
    end else if (reg_wr) begin
      if (reg_addr == 8'h10) neg_q <= reg_wdata[15];
      if (reg_addr == 8'h14) begin
        en_q  <= reg_wdata[0];
        fmt_q <= reg_wdata[6:4];
      end
      if (reg_addr == 8'h18) begin
        fl_q <= reg_wdata[2:0];
        sk_q <= reg_wdata[6:4];
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_status_rd;
    reg_rd && reg_addr == 8'h1C;
  endsequence

  AST_IDLE_LEVELS: assert property (
    settled && !en_q && sk_q == 3'h0 |-> pin_out[2:0] == (3'h1 ^ fl_q))
    else $error("idle pin levels wrong");
  AST_DRIVEN: assert property (
    settled && sk_q == 3'h0 |-> pin_oe_n[2:0] == 3'h0)
    else $error("pin not driven");
  AST_SINK_LOW: assert property (
    (pin_out & pin_oe_n) == {3*N_GEN{1'b0}})
    else $error("released pin carries a high value");
  AST_SINK_RELEASE: assert property (
    settled && !en_q |-> (pin_oe_n[2:0] & sk_q) == ((3'h1 ^ fl_q) & sk_q))
    else $error("sink-only release wrong");
  AST_READBACK_PAIR: assert property (
    s_status_rd |=> reg_rdata[6:4] == ~reg_rdata[2:0])
    else $error("inverted readback not complement");
  AST_ENABLED_RUN: assert property (
    plain && en_q |-> !pin_out[0])
    else $error("inhibit set while enabled");
  AST_UPDOWN_IDLE: assert property (
    plain && en_q && fmt_q == `FMT_UP_DOWN |-> (neg_q ? !pin_out[1] : !pin_out[2]))
    else $error("idle up/down line active");
  AST_DIR_SECONDARY: assert property (
    plain && en_q && fmt_q inside {`FMT_PWM_DIR, `FMT_PDM_DIR} |-> pin_out[2] == neg_q)
    else $error("direction on secondary wrong");
  AST_DIR_PRIMARY: assert property (
    plain && en_q && fmt_q == `FMT_DIR_PWM |-> pin_out[1] == neg_q)
    else $error("direction on primary wrong");
endmodule

bind pwm_pdm_generator_with_pin_stage pwm_pdm_monitor #(.N_GEN(N_GEN)) mon (
  .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n));

// *** test_pwm_pdm_generator_with_pin_stage.sv ***
// Self-checking bench for the pulse generator block
`timescale 1ns/100ps
module test_pwm_pdm_generator_with_pin_stage;
  localparam int NG = 2;
  localparam int NP = 3 * NG;
  logic          sys_clk = 1'b0;
  logic          nrst = 1'b0;
  logic [7:0]    reg_addr = 8'h0;
  logic [31:0]   reg_wdata = 32'h0;
  logic          reg_wr = 1'b0;
  logic          reg_rd = 1'b0;
  logic [31:0]   reg_rdata;
  logic [NP-1:0] pin_in;
  logic [NP-1:0] pin_out;
  logic [NP-1:0] pin_oe_n;
  logic [NP-1:0] ext_low = '0;
  logic          clr = 1'b0;
  logic [15:0]   hi [NP];
  int            n_errors = 0;
  int            num_checks = 0;

  always #4 sys_clk = ~sys_clk;

  pwm_pdm_generator_with_pin_stage #(.N_GEN(NG)) dut (.sys_clk(sys_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  drive_model #(.NP(NP)) far (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_low(ext_low), .clr(clr), .pin_in(pin_in), .hi(hi));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
    // Read data stands one cycle only, then returns to zero
    @(posedge sys_clk);
    #1;
    chk(reg_rdata, 32'h0);
  endtask

  // Configure every generator alike, then count high cycles over one PWM period
  // Ramp steps every second cycle, so a period is 1024 cycles; counts given per 512 steps
  task automatic run(input logic en, input logic [2:0] f, input logic [15:0] d,
                     input logic [15:0] ei, input logic [15:0] e1, input logic [15:0] e2);
    for (int g = 1; g <= NG; g++) begin
      wr(8'(g * 16), {16'h0, d});
      wr(8'(g * 16 + 4), {25'h0, f, 3'h0, en});
    end
    repeat (520) @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (1024) @(posedge sys_clk);
    #1;
    for (int g = 0; g < NG; g++) begin
      chk({16'h0, hi[3*g]}, {15'h0, ei, 1'b0});
      chk({16'h0, hi[3*g+1]}, {15'h0, e1, 1'b0});
      chk({16'h0, hi[3*g+2]}, {15'h0, e2, 1'b0});
    end
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(8'h00, 32'h100);
    rd(8'h04, 32'h100);
    rd(8'h14, 32'h10);
    rd(8'hFC, 32'h0);
    chk({26'h0, pin_out}, 32'h9);
    chk({26'h0, pin_oe_n}, 32'h0);
    $display("Test reset values done");
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'hFFFFFF);
    wr(8'h04, 32'h1FFFF);
    rd(8'h04, 32'hFFFF);
    wr(8'h04, 32'h4000);
    rd(8'h04, 32'h4000);
    // Half-scale word gives an exact ramp step every second cycle
    wr(8'h00, 32'h800000);
    rd(8'h00, 32'h800000);
    $display("Test rate clamp done");
    run(1'b0, 3'h1, 16'h2000, 16'd512, 16'd0, 16'd0);
    run(1'b1, 3'h1, 16'h2000, 16'd0, 16'd256, 16'd0);
    run(1'b1, 3'h1, 16'hF000, 16'd0, 16'd128, 16'd512);
    run(1'b1, 3'h1, 16'h8000, 16'd0, 16'd512, 16'd512);
    run(1'b1, 3'h2, 16'h1000, 16'd0, 16'd128, 16'd0);
    run(1'b1, 3'h2, 16'hF000, 16'd0, 16'd0, 16'd128);
    run(1'b1, 3'h3, 16'h2000, 16'd0, 16'd256, 16'd0);
    run(1'b1, 3'h3, 16'h0800, 16'd0, 16'd64, 16'd0);
    run(1'b1, 3'h3, 16'hC000, 16'd0, 16'd512, 16'd512);
    run(1'b1, 3'h3, 16'h8000, 16'd0, 16'd512, 16'd512);
    run(1'b1, 3'h4, 16'hF000, 16'd0, 16'd512, 16'd128);
    run(1'b1, 3'h5, 16'h2000, 16'd0, 16'd0, 16'd0);
    $display("Test output formats done");
    run(1'b0, 3'h1, 16'h0, 16'd512, 16'd0, 16'd0);
    wr(8'h18, 32'h07);
    repeat (6) @(posedge sys_clk);
    chk({29'h0, pin_out[2:0]}, 32'h6);
    rd(8'h1C, 32'h16);
    wr(8'h18, 32'h70);
    repeat (6) @(posedge sys_clk);
    chk({29'h0, pin_oe_n[2:0]}, 32'h1);
    rd(8'h1C, 32'h61);
    ext_low <= 6'h1;
    repeat (6) @(posedge sys_clk);
    rd(8'h1C, 32'h70);
    wr(8'h18, 32'h77);
    repeat (6) @(posedge sys_clk);
    rd(8'h1C, 32'h16);
    $display("Test pin stage done");
    results();
  end
endmodule
